// ---- rtl/sew_defines.svh ----
// Constants for the serial data EEPROM slave and its port register
`ifndef SEW_DEFINES_SVH
`define SEW_DEFINES_SVH

// Register offsets on the plain register port
`define SEW_GPIO_ADDR 8'h06
`define SEW_STAT_ADDR 8'h07
`define SEW_PEEK_ADDR 8'h08

// Bit positions of the serial lines inside the port register
`define SEW_SDA_BIT 6
`define SEW_SCL_BIT 7

// Port register reset value: both serial lines high
`define SEW_GPIO_RST 8'hc0

// Control byte device code and byte length
`define SEW_DEV_CODE 4'ha
`define SEW_BYTE_BITS 4'h8

// Status register fields
`define SEW_STAT_BUSY 0
`define SEW_STAT_UV 1
`define SEW_STAT_PTR_LO 4

// Memory size in bytes
`define SEW_MEM_DEPTH 16

// Self-timed write cycle length and clock rate
`define SEW_WR_TIME_US 4000
`define SEW_CLK_MHZ 125

`endif

// ---- rtl/sew_pkg.sv ----
// Types shared by the serial data EEPROM slave
package sew_pkg;

	// Protocol engine states
	typedef enum logic [2:0] {
		st_idle,
		st_ctrl,
		st_addr,
		st_data,
		st_skip
	} sew_state_t;

endpackage : sew_pkg

// ---- rtl/sew_wtimer.sv ----
// Self-timed write cycle counter
`timescale 1ns/10ps
`include "sew_defines.svh"

module sew_wtimer #(
	parameter int unsigned CYCLES = `SEW_WR_TIME_US * `SEW_CLK_MHZ
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start,
	output logic busy,
	output logic done
);
	import sew_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_reg;

	// Busy while counting, done on the last busy cycle
	assign busy = (cnt_reg != '0);
	assign done = (cnt_reg == CW'(1));

	// Load on start when idle, then count down to zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= '0;
		end else if (start && !busy) begin
			cnt_reg <= CW'(CYCLES);
		end else if (busy) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// (R23) full count loaded
	a_timer_load: assert property (@(posedge clock) disable iff (!reset_n)
		start && !busy |=> cnt_reg == CW'(CYCLES)) // (R23)
		else $error("write timer not loaded with full count");

endmodule : sew_wtimer

// ---- rtl/sew_eeprom.sv ----
// Two-wire data EEPROM slave with its port register
//
// Function
// (R1) Data bit6, clock bit7 of register 06h
// (R2) Data line pull-down only, one after reset
// (R3) Clock line push-pull, one after reset
// (R4) Master writes one before sampling data
// (R5) Data changes only while clock low
// (R6) Idle means both lines high
// (R7) Data falling with clock high is START
// (R8) Data rising with clock high is STOP
// (R9) Receiver holds data low on ninth pulse
// (R10) Leave data high after master's final nack
// (R11) Control byte: code 1010, three ignored, direction
// (R12) Direction one reads, zero writes; a read gets its control ack but no data
// (R13) Acknowledge address only when not programming
// (R14) Address byte low four bits load pointer
// (R15) Ack address, data; STOP starts write
// (R16) Pointer stays on written location
// (R17) Early STOP aborts, stores nothing
// (R18) Extra bits restart the data buffer
// (R19) Partial second byte at STOP aborts
// (R20) Undervoltage blocks erase and write
// (R21) Master idles bus around byte writes
// (R22) No acknowledge while busy; polling works
// (R23) Write cycle is a parameter counter
`timescale 1ns/10ps
`include "sew_defines.svh"

module sew_eeprom #(
	parameter int unsigned WR_CYCLES = `SEW_WR_TIME_US * `SEW_CLK_MHZ,
	parameter int MEM_DEPTH = `SEW_MEM_DEPTH
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic undervolt,
	output logic scl_line_o,
	output logic sda_line_o,
	output logic busy_o,
	output sew_pkg::sew_state_t state_o
);
	import sew_pkg::*;

	localparam int AW = $clog2(MEM_DEPTH);

	////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] gpio_reg;
	logic [7:0] rd_data_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic uv_meta_reg;
	logic uv_sync_reg;
	sew_state_t st_reg;
	sew_state_t st_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic phase9_reg;
	logic phase9_next;
	logic ack_drv_reg;
	logic ack_drv_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [AW-1:0] addr_ptr_reg;
	logic [AW-1:0] addr_ptr_next;
	logic [7:0] data_buf_reg;
	logic [7:0] data_buf_next;
	logic have_byte_reg;
	logic have_byte_next;
	logic [7:0] mem_reg [MEM_DEPTH];
	logic busy;
	logic cyc_done;

	////////////////////////////////////////////////////////////////////
	// Register port decode

	// Address decode and strobes
	wire gpio_sel = (addr == `SEW_GPIO_ADDR);
	wire stat_sel = (addr == `SEW_STAT_ADDR);
	wire peek_sel = (addr == `SEW_PEEK_ADDR);
	wire gpio_wr = wr_en && gpio_sel;

	// (R3) clock line driven
	wire scl_line = gpio_reg[`SEW_SCL_BIT];
	// (R2) open-drain data line
	// (R4) released latch lets slave pull
	wire sda_line = gpio_reg[`SEW_SDA_BIT] & ~ack_drv_reg;

	// Status word and memory peek at the pointer
	wire [7:0] stat_word = {addr_ptr_reg, 2'h0, uv_sync_reg, busy};
	wire [7:0] peek_word = mem_reg[addr_ptr_reg];

	// (R1) lines seen in bits 7 and 6
	wire [7:0] gpio_word = {scl_line, sda_line, gpio_reg[5:0]};

	// Read data select; unmapped addresses read zero
	wire [7:0] rd_next = gpio_sel ? gpio_word :
		stat_sel ? stat_word :
		peek_sel ? peek_word : 8'h00;

	// (R1) port register, lines reset high
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gpio_reg <= `SEW_GPIO_RST;
		end else if (gpio_wr) begin
			gpio_reg <= wr_data;
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_reg <= 8'h00;
		end else begin
			rd_data_reg <= rd_en ? rd_next : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Line sampling and condition detection

	// Previous line levels and undervoltage synchroniser
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			uv_meta_reg <= 1'b0;
			uv_sync_reg <= 1'b0;
		end else begin
			scl_prev_reg <= scl_line;
			sda_prev_reg <= sda_line;
			uv_meta_reg <= undervolt;
			uv_sync_reg <= uv_meta_reg;
		end
	end

	// Clock edges
	wire scl_rise = scl_line && !scl_prev_reg;
	wire scl_fall = !scl_line && scl_prev_reg;
	wire scl_held = scl_line && scl_prev_reg;

	// (R6) idle is both high
	// (R7) falling data, clock high
	wire start_det = scl_held && sda_prev_reg && !sda_line;
	// (R8) rising data, clock high
	wire stop_det = scl_held && !sda_prev_reg && sda_line;

	// Byte boundary events
	wire byte_end = scl_fall && !phase9_reg &&
		(bit_cnt_reg == `SEW_BYTE_BITS);
	wire bit_take = scl_rise && !phase9_reg &&
		(bit_cnt_reg < `SEW_BYTE_BITS);

	// (R11) device code check
	wire code_ok = (shift_reg[7:4] == `SEW_DEV_CODE);
	// (R13) no acknowledge while programming
	wire ctrl_match = code_ok && !busy;
	// (R12) direction bit
	wire dir_read = shift_reg[0];

	// (R15) STOP after whole byte write launches
	// (R17) early STOP aborts
	// (R19) partial byte aborts
	// (R20) undervoltage blocks the write
	// The clock rise just ahead of STOP takes one bit that is not data
	wire launch = stop_det && (st_reg == st_data) && have_byte_reg &&
		(bit_cnt_reg <= 4'h1) && !phase9_reg && !uv_sync_reg;

	////////////////////////////////////////////////////////////////////
	// Protocol engine

	// Next state of the receiver
	always_comb begin
		st_next = st_reg;
		bit_cnt_next = bit_cnt_reg;
		phase9_next = phase9_reg;
		ack_drv_next = ack_drv_reg;
		shift_next = shift_reg;
		addr_ptr_next = addr_ptr_reg;
		data_buf_next = data_buf_reg;
		have_byte_next = have_byte_reg;
		if (start_det) begin
			st_next = st_ctrl;
			bit_cnt_next = 4'h0;
			phase9_next = 1'b0;
			ack_drv_next = 1'b0;
			have_byte_next = 1'b0;
		end else if (stop_det) begin
			st_next = st_idle;
			bit_cnt_next = 4'h0;
			phase9_next = 1'b0;
			ack_drv_next = 1'b0;
			have_byte_next = 1'b0;
		end else if (st_reg != st_idle) begin
			// (R5) sample while clock rises
			if (bit_take) begin
				shift_next = {shift_reg[6:0], sda_line};
				bit_cnt_next = bit_cnt_reg + 4'h1;
			end
			// (R9) release after ninth pulse
			if (scl_fall && phase9_reg) begin
				phase9_next = 1'b0;
				ack_drv_next = 1'b0;
				bit_cnt_next = 4'h0;
			end
			if (byte_end) begin
				phase9_next = 1'b1;
				unique case (st_reg)
					st_ctrl: begin
						// (R22) busy control byte gets no ack
						if (ctrl_match) begin
							ack_drv_next = 1'b1;
							st_next = dir_read ? st_skip : st_addr;
						end else begin
							st_next = st_skip;
						end
					end
					st_addr: begin
						// (R14) low bits into pointer
						ack_drv_next = 1'b1;
						addr_ptr_next = shift_reg[AW-1:0];
						st_next = st_data;
					end
					st_data: begin
						// (R15) (R18) newest byte fills buffer
						ack_drv_next = 1'b1;
						data_buf_next = shift_reg;
						have_byte_next = 1'b1;
					end
					// (R10) line left high
					st_skip: begin
						ack_drv_next = 1'b0;
					end
					st_idle: begin
						ack_drv_next = 1'b0;
					end
				endcase
			end
		end
	end

	// Engine registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= st_idle;
			bit_cnt_reg <= 4'h0;
			phase9_reg <= 1'b0;
			ack_drv_reg <= 1'b0;
			shift_reg <= 8'h00;
			addr_ptr_reg <= '0;
			data_buf_reg <= 8'h00;
			have_byte_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			bit_cnt_reg <= bit_cnt_next;
			phase9_reg <= phase9_next;
			ack_drv_reg <= ack_drv_next;
			shift_reg <= shift_next;
			addr_ptr_reg <= addr_ptr_next;
			data_buf_reg <= data_buf_next;
			have_byte_reg <= have_byte_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Write cycle and storage

	// (R23) parameter-length write cycle
	sew_wtimer #(
		.CYCLES(WR_CYCLES)
	) u_wtimer (
		.clock(clock),
		.reset_n(reset_n),
		.start(launch),
		.busy(busy),
		.done(cyc_done)
	);

	// (R20) commit blocked on undervoltage
	wire commit = cyc_done && !uv_sync_reg;

	// (R16) pointer kept, byte stored at end
	always_ff @(posedge clock) begin
		if (commit) begin
			mem_reg[addr_ptr_reg] <= data_buf_reg;
		end
	end

	// Outputs
	assign rd_data = rd_data_reg;
	assign scl_line_o = scl_line;
	assign sda_line_o = sda_line;
	assign busy_o = busy;
	assign state_o = st_reg;

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// (R13) control acknowledge only when idle
	a_ctrl_ack_idle: assert property ( // (R13)
		byte_end && st_reg == st_ctrl && ack_drv_next |-> !busy)
		else $error("control byte acknowledged while busy");

	// (R22) no acknowledge during write cycle
	a_busy_no_ack: assert property ( // (R22)
		busy |-> !ack_drv_reg)
		else $error("acknowledge driven during write cycle");

	// (R5) drive changes only with clock low
	a_ack_clock_low: assert property ( // (R5)
		$changed(ack_drv_reg) |-> !scl_line && !$past(scl_line))
		else $error("data drive changed while clock high");

	// (R9) ack held through the ninth pulse
	a_ack_ninth: assert property ( // (R9)
		$rose(ack_drv_reg) |-> phase9_reg until $fell(ack_drv_reg))
		else $error("acknowledge outside the ninth pulse");

	// (R7) START enters control byte
	a_start_ctrl: assert property ( // (R7)
		start_det |=> st_reg == st_ctrl && bit_cnt_reg == 4'h0)
		else $error("START did not restart control byte");

	// (R8) STOP returns to idle
	a_stop_idle: assert property ( // (R8)
		stop_det |=> st_reg == st_idle && !ack_drv_reg)
		else $error("STOP did not return to idle");

	// (R14) pointer takes low address bits
	a_addr_load: assert property ( // (R14)
		byte_end && st_reg == st_addr
		|=> addr_ptr_reg == $past(shift_reg[AW-1:0]))
		else $error("address pointer not loaded");

	// (R17) no launch without complete byte
	a_abort_nowrite: assert property ( // (R17)
		stop_det && !busy && (!have_byte_reg || bit_cnt_reg > 4'h1)
		|=> !busy)
		else $error("write started without a full byte");

	// (R15) launch makes the device busy
	a_launch_busy: assert property ( // (R15)
		launch && !busy |=> busy [*2])
		else $error("write cycle not started by STOP");

	// (R16) written byte at unchanged pointer
	a_store_ptr: assert property ( // (R16)
		commit |=> peek_word == $past(data_buf_reg) &&
		$stable(addr_ptr_reg))
		else $error("byte not stored at pointer");

	// (R20) no store under undervoltage
	a_uv_block: assert property ( // (R20)
		uv_sync_reg && !commit |=> $stable(peek_word) || $changed(addr_ptr_reg))
		else $error("store happened during undervoltage");

	// Main scenarios
	c_byte_write: cover property (launch);
	c_busy_nack: cover property (byte_end && st_reg == st_ctrl && busy);
	c_read_ctrl: cover property (byte_end && st_reg == st_ctrl &&
		ctrl_match && dir_read);
	c_commit: cover property (commit);

endmodule : sew_eeprom

// ---- bench/sew_host.sv ----
// Host software model that bit-bangs the two-wire master
`timescale 1ns/10ps
module sew_host (
	input wire logic clock,
	output logic [7:0] addr,
	output logic [7:0] wr_data,
	output logic wr_en,
	output logic rd_en,
	input wire logic [7:0] rd_data
);
	logic sc = 1'b1;
	logic sd = 1'b1;
	// Quiet register port at time zero
	initial begin
		addr = 8'h00;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	// One-cycle register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask : wr
	// One-cycle register read, data taken in the following cycle
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	// One line change per port write, a third of a link period each
	task put(input logic s, input logic d);
		sc = s;
		sd = d;
		wr(8'h06, {s, d, 6'h00});
		repeat (2) @(posedge clock);
	endtask : put
	task start;
		if (!sc)
			put(1'b1, 1'b1);
		put(1'b1, 1'b0);
		put(1'b0, 1'b0);
	endtask : start
	task stop;
		put(1'b0, sd);
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask : stop
	task send(input logic [7:0] b, input int nb, output logic ack);
		logic [7:0] v;
		ack = 1'b0;
		for (int i = 7; i > 7 - nb; i--) begin
			put(1'b0, sd);
			put(1'b0, b[i]);
			put(1'b1, b[i]);
		end
		if (nb == 8) begin
			put(1'b0, sd);
			put(1'b0, 1'b1);
			put(1'b1, 1'b1);
			rd(8'h06, v);
			ack = ~v[6];
			put(1'b0, 1'b1);
		end
	endtask : send
endmodule : sew_host

// ---- bench/tb.sv ----
// Self-checking bench for the two-wire data EEPROM slave
`timescale 1ns/10ps
module tb;
	import sew_pkg::*;
	localparam int unsigned WR = 400;
	logic clock, reset_n, undervolt, wr_en, rd_en, ack;
	logic busy_o, scl_line_o, sda_line_o;
	logic [7:0] addr, wr_data, rd_data, v, a, d;
	sew_state_t state_o;
	logic [7:0] mem_exp [16];
	logic [7:0] ctl_tab [5] = '{8'ha0, 8'hae, 8'ha1, 8'hb0, 8'h2e};
	logic [7:0] ack_tab [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
	int num_errors = 0;
	int num_checks = 0;

	sew_host host (.clock(clock), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
	sew_eeprom #(.WR_CYCLES(WR)) dut (.clock(clock), .reset_n(reset_n),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .undervolt(undervolt),
		.scl_line_o(scl_line_o), .sda_line_o(sda_line_o),
		.busy_o(busy_o), .state_o(state_o));

	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Compare and count
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Verdict and end of run
	task final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	// Control byte alone, then stop
	task poll(input logic [7:0] c, output logic k);
		host.start;
		host.send(c, 8, k);
		host.stop;
	endtask : poll
	task wait_idle;
		logic k;
		k = 1'b0;
		for (int n = 0; n < 20 && !k; n++)
			poll(8'ha0, k);
		if (!k) begin
			num_errors++;
			$display("[ERR] poll expected ack seen none");
			final_report;
		end
	endtask : wait_idle
	// Byte write, optionally with a further full or partial data byte
	task wbyte(input logic [7:0] wa, input logic [7:0] wd,
		input logic [7:0] wd2, input int nb2);
		host.start;
		host.send(8'ha0, 8, ack);
		chk("ctl ack", {7'h0, ack}, 8'h01);
		host.send(wa, 8, ack);
		chk("addr ack", {7'h0, ack}, 8'h01);
		host.send(wd, 8, ack);
		chk("data ack", {7'h0, ack}, 8'h01);
		if (nb2 > 0)
			host.send(wd2, nb2, ack);
		host.stop;
	endtask : wbyte

	// Main sequence
	initial begin
		reset_n = 1'b0;
		undervolt = 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		void'($urandom(17));
		host.rd(8'h06, v);
		chk("gpio reset", v, 8'hc0);
		chk("lines", {6'h0, scl_line_o, sda_line_o}, 8'h03);
		chk("state", {5'h0, state_o}, {5'h0, st_idle});
		host.rd(8'h3f, v);
		chk("unmapped", v, 8'h00);
		$display("test reset done");
		for (int k = 0; k < 3; k++) begin
			a = (k == 0) ? 8'hff : 8'($urandom);
			d = 8'($urandom);
			wbyte(a, d, 8'h00, 0);
			mem_exp[a[3:0]] = d;
			host.rd(8'h07, v);
			chk("busy", {7'h0, v[0]}, 8'h01);
			poll(8'ha0, ack);
			chk("poll busy", {7'h0, ack}, 8'h00);
			wait_idle;
			host.rd(8'h08, v);
			chk("stored", v, d);
			host.rd(8'h07, v);
			chk("pointer", {4'h0, v[7:4]}, {4'h0, a[3:0]});
		end
		$display("test byte write done");
		for (int i = 0; i < 5; i++) begin
			poll(ctl_tab[i], ack);
			chk("control ack", {7'h0, ack}, ack_tab[i]);
		end
		// Read direction: line must be free once the ack pulse ends
		host.start;
		host.send(8'ha1, 8, ack);
		chk("line free", {7'h0, sda_line_o}, 8'h01);
		host.stop;
		$display("test control byte done");
		// Stop after the address, then stop inside a second byte
		host.start;
		host.send(8'ha0, 8, ack);
		host.send(a, 8, ack);
		host.stop;
		wbyte(a, 8'($urandom), 8'($urandom), 4);
		chk("no launch", {7'h0, busy_o}, 8'h00);
		chk("stop idle", {5'h0, state_o}, {5'h0, st_idle});
		host.rd(8'h08, v);
		chk("aborted", v, mem_exp[a[3:0]]);
		d = ~mem_exp[a[3:0]];
		wbyte(a, 8'($urandom), d, 8);
		wait_idle;
		mem_exp[a[3:0]] = d;
		host.rd(8'h08, v);
		chk("second byte", v, d);
		$display("test abort done");
		@(posedge clock) undervolt <= 1'b1;
		repeat (4) @(posedge clock);
		wbyte(a, ~d, 8'h00, 0);
		host.rd(8'h07, v);
		chk("undervolt flag", {7'h0, v[1]}, 8'h01);
		wait_idle;
		host.rd(8'h08, v);
		chk("blocked", v, mem_exp[a[3:0]]);
		@(posedge clock) undervolt <= 1'b0;
		$display("test undervoltage done");
		final_report;
	end
endmodule : tb
